//--- logic/pllhc_core.sv
`timescale 1ns/1ps
module pllhc_core
  import pllhc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sync_pin_n,
  input wire logic ref_pfd_in,
  input wire logic phase_in_lock_window,
  input wire logic phase_over_unlock,
  input wire logic lock_pin_cmp_in,
  input wire logic first_ref_present,
  input wire logic second_ref_present,
  input wire logic cp_up_req,
  input wire logic cp_dn_req,
  output logic cp_up,
  output logic cp_dn,
  output logic cp_hiz,
  output logic b_counter_reset,
  output logic holdover_active,
  output logic digital_lock_flag,
  output logic lock_window_high_n,
  output logic lock_indicator_pin_src_en,
  output logic lock_indicator_pin_gnd_en,
  output logic lock_indicator_pin_o,
  output logic lock_indicator_pin_oe,
  output logic reference_monitor_pin,
  output logic status_pin,
  output logic ref_sel_second,
  output logic [1:0] ref_buffer_en
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned NSYNC = 9;

  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] meta_r;
  logic [NSYNC-1:0] sync_r;
  logic sync_prev_r;
  logic ref_prev_r;

  assign async_in = {cp_dn_req, cp_up_req, second_ref_present, first_ref_present,
                     lock_pin_cmp_in, phase_over_unlock, phase_in_lock_window,
                     ref_pfd_in, sync_pin_n};

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= {{(NSYNC-1){1'b0}}, 1'b1};
      sync_r <= {{(NSYNC-1){1'b0}}, 1'b1};
      sync_prev_r <= 1'b1;
      ref_prev_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      sync_prev_r <= sync_r[0];
      ref_prev_r <= sync_r[1];
    end
  end

  logic sync_s;
  logic ref_s;
  logic in_window_s;
  logic over_unlock_s;
  logic lock_cmp_s;
  logic first_reference_ok_s;
  logic second_reference_ok_s;
  logic up_req_s;
  logic dn_req_s;

  assign sync_s = sync_r[0];
  assign ref_s = sync_r[1];
  assign in_window_s = sync_r[2];
  assign over_unlock_s = sync_r[3];
  assign lock_cmp_s = sync_r[4];
  assign first_reference_ok_s = sync_r[5];
  assign second_reference_ok_s = sync_r[6];
  assign up_req_s = sync_r[7];
  assign dn_req_s = sync_r[8];

  logic sync_fall;
  logic ref_rise;

  // the sync pin is read for holdover only; divider sync handling lives outside
  assign sync_fall = sync_prev_r & ~sync_s;
  assign ref_rise = ref_s & ~ref_prev_r;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0] status_pin_r;
  logic [7:0] lock_det_r;
  logic [7:0] lock_pin_sel_r;
  logic [7:0] reference_monitor_pin_sel_r;
  logic [7:0] ref_sel_ctl_r;
  logic [7:0] holdover_r;

  logic hit_status_pin;
  logic hit_lock_det;
  logic hit_lock_pin_sel;
  logic hit_reference_monitor_pin_sel;
  logic hit_ref_sel;
  logic hit_holdover;
  logic hit_block_state;

  assign hit_status_pin = (reg_addr == OFS_STATUS_PIN);
  assign hit_lock_det = (reg_addr == OFS_LOCK_DET);
  assign hit_lock_pin_sel = (reg_addr == OFS_LOCK_PIN_SEL);
  assign hit_reference_monitor_pin_sel = (reg_addr == OFS_REFERENCE_MONITOR_PIN_SEL);
  assign hit_ref_sel = (reg_addr == OFS_REF_SEL);
  assign hit_holdover = (reg_addr == OFS_HOLDOVER);
  assign hit_block_state = (reg_addr == OFS_BLOCK_STATE);

  always_ff @(posedge clk) begin
    if (rst) begin
      status_pin_r <= RST_VALUE;
      lock_det_r <= RST_VALUE;
      lock_pin_sel_r <= RST_VALUE;
      reference_monitor_pin_sel_r <= RST_VALUE;
      ref_sel_ctl_r <= RST_VALUE;
      holdover_r <= RST_VALUE;
    end else if (reg_wr) begin
      if (hit_status_pin) status_pin_r <= reg_wdata;
      if (hit_lock_det) lock_det_r <= reg_wdata;
      if (hit_lock_pin_sel) lock_pin_sel_r <= reg_wdata;
      if (hit_reference_monitor_pin_sel) reference_monitor_pin_sel_r <= reg_wdata;
      if (hit_ref_sel) ref_sel_ctl_r <= reg_wdata;
      if (hit_holdover) holdover_r <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  logic ho_enabled;
  logic ho_manual;
  logic cmp_enabled;
  logic dld_enabled;
  logic [1:0] ld_count_sel;
  logic [5:0] lock_pin_func;
  logic [5:0] status_func;
  logic [4:0] reference_monitor_pin_func;
  logic lock_sensed;

  assign ho_enabled = holdover_r[HO_EN_A_BIT] & holdover_r[HO_EN_B_BIT];
  assign ho_manual = holdover_r[HO_EXT_BIT];
  assign cmp_enabled = holdover_r[HO_CMP_EN_BIT];
  assign dld_enabled = ~lock_det_r[LD_DISABLE_BIT];
  assign ld_count_sel = lock_det_r[LD_COUNT_MSB:LD_COUNT_LSB];
  assign lock_pin_func = lock_pin_sel_r[LP_SEL_MSB:0];
  assign status_func = status_pin_r[SP_SEL_MSB:SP_SEL_LSB];
  assign reference_monitor_pin_func = reference_monitor_pin_sel_r[RM_SEL_MSB:0];
  assign lock_sensed = cmp_enabled ? lock_cmp_s : 1'b1;

  // ----------------------------------------------------------------
  // reference selection
  // ----------------------------------------------------------------
  logic prefer_second;
  logic ref_pick;

  assign prefer_second = ref_sel_ctl_r[RS_PREFER_BIT];
  // auto switchover moves off the preferred input only while it is missing
  assign ref_pick = ref_sel_ctl_r[RS_AUTO_BIT]
                    ? (prefer_second ? ~(second_reference_ok_s | ~first_reference_ok_s) == 1'b0
                                     : (~first_reference_ok_s & second_reference_ok_s))
                    : prefer_second;

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_sel_second <= 1'b0;
      ref_buffer_en <= 2'b00;
    end else begin
      ref_sel_second <= ref_pick;
      ref_buffer_en <= ref_sel_ctl_r[RS_BUF_MSB:RS_BUF_LSB];
    end
  end

  // ----------------------------------------------------------------
  // digital lock detector, evaluated once per rising reference edge
  // ----------------------------------------------------------------
  logic [7:0] lock_target;
  logic [7:0] lock_cnt_r;
  logic [7:0] lock_cnt_nxt;
  logic dlf_r;
  logic dlf_nxt;

  assign lock_target = (ld_count_sel == 2'b00) ? LD_CYCLES_0 :
                       (ld_count_sel == 2'b01) ? LD_CYCLES_1 :
                       (ld_count_sel == 2'b10) ? LD_CYCLES_2 : LD_CYCLES_3;

  always_comb begin
    lock_cnt_nxt = lock_cnt_r;
    dlf_nxt = dlf_r;
    if (!dld_enabled) begin
      lock_cnt_nxt = 8'h00;
      dlf_nxt = 1'b0;
    end else if (ref_rise) begin
      if (dlf_r) begin
        if (over_unlock_s) begin
          dlf_nxt = 1'b0;
          lock_cnt_nxt = 8'h00;
        end
      end else if (in_window_s) begin
        lock_cnt_nxt = lock_cnt_r + 8'h01;
        if (lock_cnt_nxt >= lock_target) begin
          dlf_nxt = 1'b1;
          lock_cnt_nxt = 8'h00;
        end
      end else begin
        lock_cnt_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lock_cnt_r <= 8'h00;
      dlf_r <= 1'b0;
      lock_window_high_n <= 1'b0;
    end else begin
      lock_cnt_r <= lock_cnt_nxt;
      dlf_r <= dlf_nxt;
      lock_window_high_n <= lock_det_r[LD_WINDOW_BIT];
    end
  end

  assign digital_lock_flag = dlf_r;

  // ----------------------------------------------------------------
  // lock indicator pin driver
  // ----------------------------------------------------------------
  logic lp_current_mode;
  logic lp_flag_mode;

  assign lp_current_mode = (lock_pin_func == LP_CURRENT_SRC);
  assign lp_flag_mode = (lock_pin_func == LP_LOCK_FLAG);

  always_ff @(posedge clk) begin
    if (rst) begin
      lock_indicator_pin_src_en <= 1'b0;
      lock_indicator_pin_gnd_en <= 1'b0;
      lock_indicator_pin_o <= 1'b0;
      lock_indicator_pin_oe <= 1'b0;
    end else begin
      // any false cycle grounds the pin and so restarts the charge
      lock_indicator_pin_src_en <= lp_current_mode & dlf_r;
      lock_indicator_pin_gnd_en <= lp_current_mode & ~dlf_r;
      lock_indicator_pin_o <= dlf_r;
      lock_indicator_pin_oe <= lp_flag_mode;
    end
  end

  // ----------------------------------------------------------------
  // comparator result on monitor and status pins
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      reference_monitor_pin <= 1'b0;
      status_pin <= 1'b0;
    end else begin
      reference_monitor_pin <= (reference_monitor_pin_func == RM_CMP_HIGH) ? lock_cmp_s :
                               (reference_monitor_pin_func == RM_CMP_LOW) ? ~lock_cmp_s : 1'b0;
      status_pin <= (status_func == SP_CMP_HIGH) ? lock_cmp_s :
                    (status_func == SP_CMP_LOW) ? ~lock_cmp_s : 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // holdover state machine
  // ----------------------------------------------------------------
  pllhc_state_e state_r;
  pllhc_state_e state_nxt;
  logic enter_now;
  logic release_now;

  // manual entry reacts to the edge only, so a held low level does not re-enter
  assign enter_now = ho_enabled &&
                     (ho_manual ? sync_fall : ~lock_sensed);
  // ref_rise belongs to the selected reference, so holdover ends on its edge
  assign release_now = ref_rise &&
                       (ho_manual ? sync_s : 1'b1);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PLLHC_RUN: begin
        if (enter_now) state_nxt = PLLHC_HOLD;
      end
      PLLHC_HOLD: begin
        if (!ho_enabled) state_nxt = PLLHC_RUN;
        else if (release_now) state_nxt = ho_manual ? PLLHC_RUN : PLLHC_REARM;
      end
      PLLHC_REARM: begin
        // wait for the lock pin to charge before automatic entry is armed
        if (!ho_enabled || ho_manual || lock_sensed) state_nxt = PLLHC_RUN;
      end
      default: state_nxt = PLLHC_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= PLLHC_RUN;
      b_counter_reset <= 1'b0;
    end else begin
      state_r <= state_nxt;
      b_counter_reset <= (state_r == PLLHC_HOLD) && ho_enabled && release_now;
    end
  end

  // ----------------------------------------------------------------
  // charge pump gating
  // ----------------------------------------------------------------
  logic hiz_now;

  assign hiz_now = (state_r == PLLHC_HOLD) || ((state_r == PLLHC_RUN) && enter_now);
  assign cp_hiz = hiz_now;
  assign holdover_active = (state_r == PLLHC_HOLD);

  always_ff @(posedge clk) begin
    if (rst) begin
      cp_up <= 1'b0;
      cp_dn <= 1'b0;
    end else begin
      cp_up <= up_req_s & ~hiz_now;
      cp_dn <= dn_req_s & ~hiz_now;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] block_state;
  logic [7:0] rd_mux;

  assign block_state = {3'b000, ref_sel_second, lock_sensed, dlf_r,
                        state_r == PLLHC_REARM, state_r == PLLHC_HOLD};
  assign rd_mux = hit_status_pin ? status_pin_r :
                  hit_lock_det ? lock_det_r :
                  hit_lock_pin_sel ? lock_pin_sel_r :
                  hit_reference_monitor_pin_sel ? reference_monitor_pin_sel_r :
                  hit_ref_sel ? ref_sel_ctl_r :
                  hit_holdover ? holdover_r :
                  hit_block_state ? block_state : 8'h00;

  always_ff @(posedge clk) begin
    if (rst) reg_rdata <= 8'h00;
    else if (reg_rd) reg_rdata <= rd_mux;
    else reg_rdata <= 8'h00;
  end

endmodule : pllhc_core

//--- pkg/pllhc_pkg.sv
package pllhc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 10;
  localparam logic [9:0] OFS_STATUS_PIN = 10'h017;
  localparam logic [9:0] OFS_LOCK_DET = 10'h018;
  localparam logic [9:0] OFS_LOCK_PIN_SEL = 10'h01a;
  localparam logic [9:0] OFS_REFERENCE_MONITOR_PIN_SEL = 10'h01b;
  localparam logic [9:0] OFS_REF_SEL = 10'h01c;
  localparam logic [9:0] OFS_HOLDOVER = 10'h01d;
  localparam logic [9:0] OFS_BLOCK_STATE = 10'h01e;
  localparam logic [7:0] RST_VALUE = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned HO_EN_A_BIT = 0;
  localparam int unsigned HO_EXT_BIT = 1;
  localparam int unsigned HO_EN_B_BIT = 2;
  localparam int unsigned HO_CMP_EN_BIT = 3;
  localparam int unsigned LD_DISABLE_BIT = 3;
  localparam int unsigned LD_WINDOW_BIT = 4;
  localparam int unsigned LD_COUNT_LSB = 5;
  localparam int unsigned LD_COUNT_MSB = 6;
  localparam int unsigned RS_BUF_LSB = 1;
  localparam int unsigned RS_BUF_MSB = 2;
  localparam int unsigned RS_PREFER_BIT = 3;
  localparam int unsigned RS_AUTO_BIT = 4;
  localparam int unsigned SP_SEL_LSB = 2;
  localparam int unsigned SP_SEL_MSB = 7;
  localparam int unsigned LP_SEL_MSB = 5;
  localparam int unsigned RM_SEL_MSB = 4;

  // ----------------------------------------------------------------
  // pin function codes
  // ----------------------------------------------------------------
  localparam logic [5:0] LP_CURRENT_SRC = 6'h04;
  localparam logic [5:0] LP_LOCK_FLAG = 6'h01;
  localparam logic [5:0] SP_CMP_HIGH = 6'h2d;
  localparam logic [5:0] SP_CMP_LOW = 6'h3d;
  localparam logic [4:0] RM_CMP_HIGH = 5'h0d;
  localparam logic [4:0] RM_CMP_LOW = 5'h1d;

  // ----------------------------------------------------------------
  // lock counts, indexed by the two-bit counter field
  // ----------------------------------------------------------------
  localparam logic [7:0] LD_CYCLES_0 = 8'h05;
  localparam logic [7:0] LD_CYCLES_1 = 8'h10;
  localparam logic [7:0] LD_CYCLES_2 = 8'h40;
  localparam logic [7:0] LD_CYCLES_3 = 8'hff;

  typedef enum logic [1:0] {
    PLLHC_RUN = 2'b00,
    PLLHC_HOLD = 2'b01,
    PLLHC_REARM = 2'b10
  } pllhc_state_e;

endpackage : pllhc_pkg

//--- test/pllhc_core_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// holdover and lock pin checks
// ----------------------------------------------------------------
module pllhc_core_monitor
  import pllhc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic lock_pin_cmp_in,
  input wire logic sync_pin_n,
  input wire logic cp_up,
  input wire logic cp_dn,
  input wire logic cp_hiz,
  input wire logic b_counter_reset,
  input wire logic holdover_active,
  input wire logic digital_lock_flag,
  input wire logic lock_indicator_pin_src_en,
  input wire logic lock_indicator_pin_gnd_en
);
  logic [7:0] ho_r;
  logic [7:0] ld_r;
  logic en;
  assign en = ho_r[HO_EN_A_BIT] & ho_r[HO_EN_B_BIT];
  // mirrors of the holdover and lock detect registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ho_r <= 8'h00;
      ld_r <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == OFS_HOLDOVER) ho_r <= reg_wdata;
      if (reg_addr == OFS_LOCK_DET) ld_r <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_no_pump; holdover_active |-> !cp_up && !cp_dn; endproperty
  a_no_pump: assert property (p_no_pump) else $error("pump active in holdover");
  property p_hiz; holdover_active |-> cp_hiz; endproperty
  a_hiz: assert property (p_hiz) else $error("holdover without high impedance");
  property p_en_in; $rose(holdover_active) |-> $past(en); endproperty
  a_en_in: assert property (p_en_in) else $error("holdover entered while disabled");
  property p_en_off; !en |=> !holdover_active; endproperty
  a_en_off: assert property (p_en_off) else $error("holdover kept while disabled");
  property p_b_exit; b_counter_reset |-> !holdover_active && $past(holdover_active); endproperty
  a_b_exit: assert property (p_b_exit) else $error("counter reset off exit edge");
  property p_b_pulse; b_counter_reset |=> !b_counter_reset; endproperty
  a_b_pulse: assert property (p_b_pulse) else $error("counter reset too long");
  property p_man; $rose(cp_hiz) && ho_r[HO_EXT_BIT] |-> !sync_pin_n; endproperty
  a_man: assert property (p_man) else $error("manual entry without sync low");
  property p_auto;
    $rose(holdover_active) && !ho_r[HO_EXT_BIT] |-> !$past(lock_pin_cmp_in, 2) ||
      !$past(lock_pin_cmp_in, 3) || !$past(lock_pin_cmp_in, 4);
  endproperty
  a_auto: assert property (p_auto) else $error("auto entry with lock high");
  property p_cmp_off;
    !ho_r[HO_EXT_BIT] && !ho_r[HO_CMP_EN_BIT] && $past(!ho_r[HO_EXT_BIT] && !ho_r[HO_CMP_EN_BIT])
      && !$past(holdover_active) |-> !holdover_active;
  endproperty
  a_cmp_off: assert property (p_cmp_off) else $error("auto entry with comparator off");
  property p_dld_off; ld_r[LD_DISABLE_BIT] && $past(ld_r[LD_DISABLE_BIT]) |-> !digital_lock_flag;
  endproperty
  a_dld_off: assert property (p_dld_off) else $error("lock flag while disabled");
  property p_src; lock_indicator_pin_src_en |-> $past(digital_lock_flag) && !lock_indicator_pin_gnd_en;
  endproperty
  a_src: assert property (p_src) else $error("source without lock flag");
  property p_gnd; lock_indicator_pin_gnd_en |-> !$past(digital_lock_flag); endproperty
  a_gnd: assert property (p_gnd) else $error("ground with lock flag");
endmodule : pllhc_core_monitor

bind pllhc_core pllhc_core_monitor u_mon (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
  .lock_pin_cmp_in, .sync_pin_n, .cp_up, .cp_dn, .cp_hiz, .b_counter_reset, .holdover_active,
  .digital_lock_flag, .lock_indicator_pin_src_en, .lock_indicator_pin_gnd_en);

//--- test/pllhc_ref_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// reference input and phase detector
// ----------------------------------------------------------------
module pllhc_ref_model #(
  parameter int HALF = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ref_on,
  input wire logic locked,
  output logic ref_pfd_in,
  output logic phase_in_lock_window,
  output logic phase_over_unlock,
  output logic cp_up_req,
  output logic cp_dn_req,
  output logic first_ref_present
);
  logic [7:0] cnt_r;
  // reference stands low while absent
  always_ff @(posedge clk) begin
    if (rst || !ref_on) begin
      cnt_r <= 8'h00;
      ref_pfd_in <= 1'b0;
    end else if (cnt_r == 8'(HALF - 1)) begin
      cnt_r <= 8'h00;
      ref_pfd_in <= ~ref_pfd_in;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  assign phase_in_lock_window = locked;
  assign phase_over_unlock = ~locked;
  assign cp_up_req = ~locked;
  assign cp_dn_req = locked & ref_pfd_in;
  assign first_ref_present = ref_on;
endmodule : pllhc_ref_model

//--- test/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
  $display("Error %s expected %h seen %h", nm, (exp), (got)); end end
module testbench
  import pllhc_pkg::*;
;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, sync_pin_n = 1, lock_pin_cmp_in = 0;
  logic second_ref_present = 1, ref_on = 0, locked = 0;
  logic [9:0] reg_addr = 10'h000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, d, v;
  logic ref_pfd_in, phase_in_lock_window, phase_over_unlock, cp_up_req, cp_dn_req;
  logic first_ref_present, cp_up, cp_dn, cp_hiz, b_counter_reset, holdover_active;
  logic digital_lock_flag, lock_window_high_n, lock_indicator_pin_src_en;
  logic lock_indicator_pin_gnd_en, lock_indicator_pin_o, lock_indicator_pin_oe;
  logic reference_monitor_pin, status_pin, ref_sel_second, got;
  logic [1:0] ref_buffer_en;
  int mismatches = 0, check_count = 0, seed = 32'hba27, i, c;
  logic [9:0] offs [6] = '{OFS_STATUS_PIN, OFS_LOCK_DET, OFS_LOCK_PIN_SEL, OFS_REFERENCE_MONITOR_PIN_SEL,
    OFS_REF_SEL, OFS_HOLDOVER};
  logic [5:0] pc [4] = '{SP_CMP_HIGH, SP_CMP_LOW, 6'(RM_CMP_HIGH), 6'(RM_CMP_LOW)};
  logic [7:0] en_tab [3] = '{8'h03, 8'h06, 8'h07};

  pllhc_core uut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sync_pin_n,
    .ref_pfd_in, .phase_in_lock_window, .phase_over_unlock, .lock_pin_cmp_in,
    .first_ref_present, .second_ref_present, .cp_up_req, .cp_dn_req, .cp_up, .cp_dn, .cp_hiz,
    .b_counter_reset, .holdover_active, .digital_lock_flag, .lock_window_high_n,
    .lock_indicator_pin_src_en, .lock_indicator_pin_gnd_en, .lock_indicator_pin_o,
    .lock_indicator_pin_oe, .reference_monitor_pin, .status_pin, .ref_sel_second,
    .ref_buffer_en);
  pllhc_ref_model #(.HALF(8)) u_ref (.clk, .rst, .ref_on, .locked, .ref_pfd_in,
    .phase_in_lock_window, .phase_over_unlock, .cp_up_req, .cp_dn_req, .first_ref_present);

  always #4 clk = ~clk;

  // ----------------------------------------------------------------
  // bus, waits and verdict
  // ----------------------------------------------------------------
  task automatic cyc(input int n); repeat (n) @(posedge clk); endtask : cyc
  task automatic tick; @(posedge clk); #1; endtask : tick
  task automatic wr(input logic [9:0] a, input logic [7:0] w);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, w};
    @(posedge clk) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] a, output logic [7:0] r);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 1'b0;
    #1 r = reg_rdata;
  endtask : rd
  task automatic wait_hiz;
    for (int k = 0; k < 60 && cp_hiz !== 1'b1; k++) tick();
    `CHK("hiz", cp_hiz, 1'b1)
  endtask : wait_hiz
  task automatic wait_b;
    for (int k = 0; k < 80 && b_counter_reset !== 1'b1; k++) tick();
    `CHK("b reset", b_counter_reset, 1'b1)
    `CHK("released", holdover_active, 1'b0)
  endtask : wait_b
  function automatic int lock_cycles(input int code);
    return (code == 0) ? 5 : int'(LD_CYCLES_1);
  endfunction : lock_cycles
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 6; i++) begin
      rd(offs[i], d);
      `CHK("reset value", d, RST_VALUE)
      v = 8'($random(seed));
      wr(offs[i], v);
      rd(offs[i], d);
      `CHK("readback", d, v)
    end
    v = 8'($random(seed));
    wr(10'h3ff, v);
    rd(10'h3ff, d);
    `CHK("unmapped", d, 8'h00)
    for (i = 0; i < 6; i++) wr(offs[i], 8'h00);
    for (i = 1; i >= 0; i--) begin
      wr(OFS_LOCK_DET, 8'(i << LD_WINDOW_BIT));
      cyc(2);
      tick();
      `CHK("window", lock_window_high_n, 1'(i))
    end
    wr(OFS_REF_SEL, 8'h16);
    cyc(6);
    tick();
    `CHK("buffers", ref_buffer_en, 2'b11)
    `CHK("switch away", ref_sel_second, 1'b1)
    @(posedge clk) ref_on <= 1'b1;
    cyc(6);
    tick();
    `CHK("preferred", ref_sel_second, 1'b0)
    wr(OFS_REF_SEL, 8'h08);
    cyc(3);
    tick();
    `CHK("manual second", ref_sel_second, 1'b1)
    wr(OFS_REF_SEL, 8'h16);
    wr(OFS_LOCK_PIN_SEL, {2'b00, LP_CURRENT_SRC});
    for (c = 0; c < 2; c++) begin
      @(posedge clk) locked <= 1'b0;
      repeat (2) @(posedge ref_pfd_in);
      cyc(6);
      tick();
      `CHK("unlock", digital_lock_flag, 1'b0)
      `CHK("grounded", lock_indicator_pin_gnd_en, 1'b1)
      wr(OFS_LOCK_DET, 8'(c << LD_COUNT_LSB));
      @(negedge ref_pfd_in);
      @(posedge clk) locked <= 1'b1;
      repeat (lock_cycles(c) - 1) @(posedge ref_pfd_in);
      cyc(6);
      tick();
      `CHK("early", digital_lock_flag, 1'b0)
      @(posedge ref_pfd_in);
      cyc(6);
      tick();
      `CHK("locked", digital_lock_flag, 1'b1)
      `CHK("sourcing", lock_indicator_pin_src_en, 1'b1)
    end
    // push-pull flag mode, then the detector switched off while in lock
    wr(OFS_LOCK_PIN_SEL, {2'b00, LP_LOCK_FLAG});
    cyc(2);
    tick();
    `CHK("flag pin oe", lock_indicator_pin_oe, 1'b1)
    `CHK("flag pin", lock_indicator_pin_o, 1'b1)
    wr(OFS_LOCK_DET, 8'(1 << LD_DISABLE_BIT));
    cyc(2);
    tick();
    `CHK("dld off", digital_lock_flag, 1'b0)
    `CHK("flag pin off", lock_indicator_pin_o, 1'b0)
    wr(OFS_LOCK_DET, 8'h00);
    for (i = 0; i < 4; i++) begin
      wr(i < 2 ? OFS_STATUS_PIN : OFS_REFERENCE_MONITOR_PIN_SEL, i < 2 ? {pc[i], 2'b00} : {2'b00, pc[i]});
      for (c = 0; c < 2; c++) begin
        @(posedge clk) lock_pin_cmp_in <= 1'(c);
        cyc(5);
        tick();
        got = (i < 2) ? status_pin : reference_monitor_pin;
        `CHK("cmp pin", got, 1'(c ^ (i % 2)))
      end
    end
    @(posedge clk) ref_on <= 1'b0;
    for (i = 0; i < 3; i++) begin
      wr(OFS_HOLDOVER, en_tab[i]);
      @(posedge clk) sync_pin_n <= 1'b0;
      cyc(8);
      tick();
      `CHK("manual entry", holdover_active, 1'(i == 2))
      `CHK("manual hiz", cp_hiz, 1'(i == 2))
      @(posedge clk) sync_pin_n <= 1'b1;
      v = 8'($random(seed));
      cyc(30 + int'(v[4:0]));
      tick();
      `CHK("no ref hold", holdover_active, 1'(i == 2))
    end
    @(posedge clk) ref_on <= 1'b1;
    wait_b();
    wr(OFS_HOLDOVER, 8'h00);
    @(posedge clk) sync_pin_n <= 1'b0;
    // let the synchronised falling edge pass while holdover is still off
    cyc(4);
    wr(OFS_HOLDOVER, 8'h07);
    cyc(10);
    tick();
    `CHK("level only", holdover_active, 1'b0)
    @(posedge clk) sync_pin_n <= 1'b1;
    wr(OFS_HOLDOVER, 8'h0d);
    cyc(10);
    tick();
    `CHK("lock high", holdover_active, 1'b0)
    @(posedge clk) ref_on <= 1'b0;
    @(posedge clk) lock_pin_cmp_in <= 1'b0;
    wait_hiz();
    cyc(40);
    tick();
    `CHK("auto hold", holdover_active, 1'b1)
    rd(OFS_BLOCK_STATE, d);
    `CHK("state hold", d[1:0], 2'b01)
    @(posedge clk) ref_on <= 1'b1;
    wait_b();
    cyc(40);
    tick();
    `CHK("rearm", holdover_active, 1'b0)
    rd(OFS_BLOCK_STATE, d);
    `CHK("state rearm", d[1:0], 2'b10)
    @(posedge clk) lock_pin_cmp_in <= 1'b1;
    cyc(10);
    @(posedge clk) lock_pin_cmp_in <= 1'b0;
    wait_hiz();
    wait_b();
    @(posedge clk) lock_pin_cmp_in <= 1'b1;
    cyc(6);
    wr(OFS_HOLDOVER, 8'h05);
    @(posedge clk) lock_pin_cmp_in <= 1'b0;
    cyc(30);
    tick();
    `CHK("cmp off", holdover_active, 1'b0)
    wr(OFS_HOLDOVER, 8'h00);
    give_verdict();
  end
endmodule : testbench
